// ---- logic/mfs_map.vh ----
// Register map, field positions and limits of the motor fault supervisor.
// Assumes a 32-bit classic Wishbone bus and a 20 MHz clock.
`ifndef MFS_MAP_VH
`define MFS_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MFS_CTRL     8'h00
`define MFS_RATED    8'h04
`define MFS_LIMITS   8'h08
`define MFS_TIMES    8'h0C
`define MFS_IMB      8'h10
`define MFS_CODE     8'h14
`define MFS_STATUS   8'h18
`define MFS_MASK     8'h1C
`define MFS_HIST_LO  8'h20
`define MFS_HIST_HI  8'h24
// ----------------------------------------
// Control fields
// ----------------------------------------
`define MFS_C_UCEN   0
`define MFS_C_STEN   1
`define MFS_C_UPEN   2
`define MFS_C_AREN   3
`define MFS_C_ALM_LO 4
`define MFS_C_ALM_HI 7
`define MFS_C_MRST   8
`define MFS_CTRL_RST 32'h0000_0003
// ----------------------------------------
// Fixed limits in 0.1 V, 0.1 Hz and ms units, and scale factors
// ----------------------------------------
`define MFS_SUP_MIN  16'h03A7
`define MFS_FRQ_MIN  16'h01A9
`define MFS_FRQ_MAX  16'h02B2
`define MFS_FRQ_MS   16'h01F4
`define MFS_PCT      32'h0000_0064
`define MFS_TENTH    32'h0000_000A
// ----------------------------------------
// Fault codes
// ----------------------------------------
`define MFS_E70      8'h46
`define MFS_E71      8'h47
`define MFS_E72      8'h48
`define MFS_E74      8'h4A
`define MFS_E75      8'h4B
`define MFS_E76      8'h4C
`define MFS_E77      8'h4D
`define MFS_E78      8'h4E
`define MFS_E85      8'h55
`define MFS_E86      8'h56
`define MFS_A90      8'h5A
`define MFS_NONE     8'h00
`endif

// ---- logic/mfs_supervisor.v ----
// Motor fault supervisor: limit checks, fault latch, history, Wishbone regs.
// Assumes measurements arrive on clk_i; contact and reset pins do not.
`timescale 1ns/100ps
`include "mfs_map.vh"
module mfs_supervisor #(
    parameter MS_CYCLES = 20000,
    parameter TW        = 16
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Measurements, same clock
    input  wire [15:0] supply_dv_i,
    input  wire [15:0] freq_dhz_i,
    input  wire [15:0] cur_a_i,
    input  wire [15:0] cur_b_i,
    input  wire [15:0] cur_c_i,
    input  wire [7:0]  torque_pct_i,
    input  wire [7:0]  power_pct_i,
    input  wire        ramp_end_i,
    input  wire        full_voltage_i,
    input  wire        motor_running_i,
    input  wire        user_program_present_i,
    input  wire [3:0]  user_fault_force_i,
    input  wire [3:0]  user_alarm_force_i,
    // Pins
    input  wire        bypass_cmd_i,
    input  wire        bypass_closed_pin_i,
    input  wire        dig_reset_pin_i,
    // Results
    output reg         motor_enable_o,
    output reg         fault_o,
    output reg  [7:0]  fault_code_o,
    output reg         alarm_o,
    output reg         irq_o
);
// ----------------------------------------
// Registers and state
// ----------------------------------------
reg  [31:0] ctrl;
reg  [15:0] starter_rated_current;
reg  [15:0] motor_rated_current;
reg  [7:0]  imbalance_limit_pct;
reg  [TW-1:0] imbalance_time;
reg  [7:0]  undertorque_limit;
reg  [7:0]  overtorque_limit;
reg  [7:0]  underpower_limit;
reg  [7:0]  overpower_limit;
reg  [TW-1:0] torque_time;
reg  [TW-1:0] power_time;
reg  [1:0]  status;
reg  [1:0]  mask;
reg  [7:0]  fcode;
reg  [3:0]  ualarm;
reg  [7:0]  hist [0:5];
reg  [1:0]  byp_sync;
reg  [1:0]  drst_sync;
reg  [31:0] ms_cnt;
reg         ms_tick;
reg  [TW-1:0] tmr [0:5];
reg  [5:0]  tmr_trip;
reg  [7:0]  next_code;
reg         alarm_q;
reg  [15:0] i_max;
reg  [15:0] i_min;
integer     j, k;
wire        undercurrent_bypass_check_enable = ctrl[`MFS_C_UCEN];
wire        bypass_stuck_check_enable        = ctrl[`MFS_C_STEN];
wire        user_program_enable              = ctrl[`MFS_C_UPEN];
wire        auto_reset_en                    = ctrl[`MFS_C_AREN];
wire [3:0]  alm_mode = ctrl[`MFS_C_ALM_HI:`MFS_C_ALM_LO];
wire        byp_closed = byp_sync[1];
wire        dig_reset  = drst_sync[1];
wire        wb_req = cyc_i & stb_i & ~ack_o;
wire        wb_wr  = wb_req & we_i & (sel_i == 4'hF);
wire        man_reset = wb_wr & (adr_i == `MFS_CTRL) & dat_i[`MFS_C_MRST];
// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        byp_sync  <= 2'h0;
        drst_sync <= 2'h0;
    end
    else
    begin
        byp_sync  <= {byp_sync[0], bypass_closed_pin_i};
        drst_sync <= {drst_sync[0], dig_reset_pin_i};
    end
end
// ----------------------------------------
// Millisecond tick
// ----------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ms_cnt  <= 32'h0;
        ms_tick <= 1'b0;
    end
    else
    begin
        ms_tick <= (ms_cnt == MS_CYCLES - 1);
        if (ms_cnt == MS_CYCLES - 1)
            ms_cnt <= 32'h0;
        else
            ms_cnt <= ms_cnt + 32'h1;
    end
end
// ----------------------------------------
// Limit comparisons
// ----------------------------------------
always @*
begin
    i_max = cur_a_i;
    i_min = cur_a_i;
    if (cur_b_i > i_max) i_max = cur_b_i;
    if (cur_c_i > i_max) i_max = cur_c_i;
    if (cur_b_i < i_min) i_min = cur_b_i;
    if (cur_c_i < i_min) i_min = cur_c_i;
end
// Products kept at 32 bits so no limit product wraps
wire [31:0] imb_lhs = {16'h0, i_max - i_min} * `MFS_PCT;
wire [31:0] imb_rhs = {24'h0, imbalance_limit_pct} *
                      {16'h0, motor_rated_current};
wire [5:0]  tcond;
assign tcond[0] = imb_lhs > imb_rhs;
assign tcond[1] = (freq_dhz_i < `MFS_FRQ_MIN) |
                  (freq_dhz_i > `MFS_FRQ_MAX);
assign tcond[2] = torque_pct_i < undertorque_limit;
assign tcond[3] = torque_pct_i > overtorque_limit;
assign tcond[4] = power_pct_i < underpower_limit;
assign tcond[5] = power_pct_i > overpower_limit;
wire [TW-1:0] tlim [0:5];
assign tlim[0] = imbalance_time;
assign tlim[1] = `MFS_FRQ_MS;
assign tlim[2] = torque_time;
assign tlim[3] = torque_time;
assign tlim[4] = power_time;
assign tlim[5] = power_time;
// ----------------------------------------
// Time-qualified checks
// ----------------------------------------
genvar g;
generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_tmr
        always @(posedge clk_i)
        begin
            if (rst_i | ~tcond[g])
            begin
                tmr[g]      <= {TW{1'b0}};
                tmr_trip[g] <= 1'b0;
            end
            else if (ms_tick & ~tmr_trip[g])
            begin
                tmr[g]      <= tmr[g] + 1'b1;
                tmr_trip[g] <= (tmr[g] >= tlim[g]);
            end
        end
    end
endgenerate
// ----------------------------------------
// Fault detection
// ----------------------------------------
wire [31:0] ramp_i2 = {16'h0, i_max};
wire [31:0] rated32 = {16'h0, starter_rated_current};
wire det70 = supply_dv_i < `MFS_SUP_MIN;
wire det71 = full_voltage_i & bypass_cmd_i & ~byp_closed;
wire det72 = ramp_end_i & (ramp_i2 >= (rated32 << 1));
wire det76 = ramp_end_i & undercurrent_bypass_check_enable &
             (ramp_i2 * `MFS_TENTH < rated32);
wire det77 = bypass_stuck_check_enable & ~bypass_cmd_i &
             byp_closed;
wire det85 = user_program_enable & ~user_program_present_i;
wire [3:0] trq_pwr = tmr_trip[5:2];
wire [3:0] tp_flt  = trq_pwr & ~alm_mode;
wire [3:0] tp_alm  = trq_pwr & alm_mode;
// Lowest code wins when several appear in one cycle
always @*
begin
    next_code = `MFS_NONE;
    k = 0;
    if (det70)
        next_code = `MFS_E70;
    else if (det71)
        next_code = `MFS_E71;
    else if (det72)
        next_code = `MFS_E72;
    else if (tmr_trip[0])
        next_code = `MFS_E74;
    else if (tmr_trip[1])
        next_code = `MFS_E75;
    else if (det76)
        next_code = `MFS_E76;
    else if (det77)
        next_code = `MFS_E77;
    else if (tp_flt[0])
        next_code = `MFS_E78;
    else if (tp_flt[1])
        next_code = `MFS_E78 + 8'h1;
    else if (tp_flt[2])
        next_code = `MFS_E78 + 8'h2;
    else if (tp_flt[3])
        next_code = `MFS_E78 + 8'h3;
    else if (det85)
        next_code = `MFS_E85;
    else
    begin
        for (k = 3; k >= 0; k = k - 1)
            if (user_fault_force_i[k])
                next_code = `MFS_E86 + k[7:0];
    end
end
// Codes that may clear themselves once their cause is gone
wire auto_ok = auto_reset_en & (
       (fcode == `MFS_E70 & ~det70) |
       (fcode == `MFS_E74 & ~tmr_trip[0]) |
       (fcode == `MFS_E78 & ~tp_flt[0]) |
       (fcode == `MFS_E78 + 8'h1 & ~tp_flt[1]) |
       (fcode == `MFS_E78 + 8'h2 & ~tp_flt[2]) |
       (fcode == `MFS_E78 + 8'h3 & ~tp_flt[3]));
wire clr_all = man_reset | dig_reset;
wire latch   = (fcode == `MFS_NONE) & (next_code != `MFS_NONE);
wire keep_h  = ~((next_code == `MFS_E70) & ~motor_running_i);
// ----------------------------------------
// Fault latch and history
// ----------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        fcode <= `MFS_NONE;
        for (j = 0; j < 6; j = j + 1)
            hist[j] <= `MFS_NONE;
    end
    else if (clr_all | auto_ok)
        fcode <= `MFS_NONE;
    else if (latch)
    begin
        fcode <= next_code;
        if (keep_h)
        begin
            hist[0] <= next_code;
            for (j = 1; j < 6; j = j + 1)
                hist[j] <= hist[j-1];
        end
    end
end
// Forced user alarms hold until a reset source clears them
always @(posedge clk_i)
begin
    if (rst_i | clr_all)
        ualarm <= 4'h0;
    else
        ualarm <= ualarm | user_alarm_force_i;
end
wire alarm_now = (|tp_alm) | (|ualarm);
// ----------------------------------------
// Outputs and interrupt
// ----------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        motor_enable_o <= 1'b0;
        fault_o        <= 1'b0;
        fault_code_o   <= `MFS_NONE;
        alarm_o        <= 1'b0;
        alarm_q        <= 1'b0;
        irq_o          <= 1'b0;
    end
    else
    begin
        motor_enable_o <= (fcode == `MFS_NONE) & ~latch;
        fault_o        <= fcode != `MFS_NONE;
        fault_code_o   <= fcode;
        alarm_o        <= alarm_now;
        alarm_q        <= alarm_now;
        irq_o          <= |(status & mask);
    end
end
// ----------------------------------------
// Wishbone register file
// ----------------------------------------
// Partial-word writes are ignored; every field needs the whole word
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_o                 <= 1'b0;
        dat_o                 <= 32'h0;
        ctrl                  <= `MFS_CTRL_RST;
        starter_rated_current <= 16'h0;
        motor_rated_current   <= 16'h0;
        imbalance_limit_pct   <= 8'h0;
        imbalance_time        <= {TW{1'b0}};
        undertorque_limit     <= 8'h0;
        overtorque_limit      <= 8'hFF;
        underpower_limit      <= 8'h0;
        overpower_limit       <= 8'hFF;
        torque_time           <= {TW{1'b0}};
        power_time            <= {TW{1'b0}};
        status                <= 2'h0;
        mask                  <= 2'h0;
    end
    else
    begin
        ack_o <= wb_req;
        // Set beats clear so an event in the clear cycle survives
        status <= (status & ~((wb_wr & adr_i == `MFS_STATUS) ?
                              dat_i[1:0] : 2'h0)) |
                  {alarm_now & ~alarm_q, latch};
        if (wb_wr)
        begin
            case (adr_i)
                `MFS_CTRL: ctrl <= {24'h0, dat_i[7:0]};
                `MFS_RATED:
                begin
                    starter_rated_current <= dat_i[15:0];
                    motor_rated_current   <= dat_i[31:16];
                end
                `MFS_LIMITS:
                begin
                    undertorque_limit <= dat_i[7:0];
                    overtorque_limit  <= dat_i[15:8];
                    underpower_limit  <= dat_i[23:16];
                    overpower_limit   <= dat_i[31:24];
                end
                `MFS_TIMES:
                begin
                    torque_time <= dat_i[15:0];
                    power_time  <= dat_i[31:16];
                end
                `MFS_IMB:
                begin
                    imbalance_limit_pct <= dat_i[7:0];
                    imbalance_time      <= dat_i[31:16];
                end
                `MFS_MASK: mask <= dat_i[1:0];
                default: ;
            endcase
        end
        dat_o <= 32'h0;
        if (wb_req & ~we_i)
        begin
            case (adr_i)
                `MFS_CTRL:    dat_o <= ctrl;
                `MFS_RATED:   dat_o <= {motor_rated_current,
                                        starter_rated_current};
                `MFS_LIMITS:  dat_o <= {overpower_limit, underpower_limit,
                                        overtorque_limit, undertorque_limit};
                `MFS_TIMES:   dat_o <= {power_time, torque_time};
                `MFS_IMB:     dat_o <= {imbalance_time, 8'h0,
                                        imbalance_limit_pct};
                `MFS_CODE:    dat_o <= {16'h0, ualarm, tp_alm, fcode};
                `MFS_STATUS:  dat_o <= {30'h0, status};
                `MFS_MASK:    dat_o <= {30'h0, mask};
                `MFS_HIST_LO: dat_o <= {hist[3], hist[2], hist[1], hist[0]};
                `MFS_HIST_HI: dat_o <= {16'h0, hist[5], hist[4]};
                default:      dat_o <= 32'h0;
            endcase
        end
    end
end
endmodule

// ---- dv/mfs_bypass_model.sv ----
// Bypass relay model: the contact follows the command after DLY cycles.
// Assumes the bench changes command and fault inputs on the rising edge.
`timescale 1ns/100ps
module mfs_bypass_model #(
    parameter DLY = 2
) (
    // Clock
    input  wire clk_i,
    // Command and injected faults
    input  wire cmd_i,
    input  wire stuck_closed_i,
    input  wire stuck_open_i,
    // Contact
    output wire contact_o
);
    reg [DLY-1:0] sh = '0;
    // A welded contact ignores the coil; an open one forgets its history,
    // so releasing it never shows a stale closed contact
    always @(posedge clk_i)
        sh <= stuck_open_i ? '0 : {sh[DLY-2:0], cmd_i};
    assign contact_o = ~stuck_open_i & (stuck_closed_i | sh[DLY-1]);
endmodule

// ---- dv/mfs_supervisor_properties.sv ----
// Port-level checks for the fault supervisor.
// Assumes auto reset stays off and MS_CYCLES matches the instance.
`timescale 1ns/100ps
`include "mfs_map.vh"
module mfs_supervisor_properties #(
    parameter MS_CYCLES = 20000
) (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Bus
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // Causes
    input wire [15:0] supply_dv_i,
    input wire [15:0] freq_dhz_i,
    input wire [3:0]  user_fault_force_i,
    input wire [3:0]  user_alarm_force_i,
    input wire        dig_reset_pin_i,
    // Results
    input wire        motor_enable_o,
    input wire        fault_o,
    input wire        alarm_o
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Late bound allows two ticks of timer slop plus latch latency
    localparam int FRQ_LATE = 503 * MS_CYCLES + 4;
    reg [5:0]  dig_q;
    reg [31:0] frq_cnt;
    wire frq_bad = freq_dhz_i < `MFS_FRQ_MIN || freq_dhz_i > `MFS_FRQ_MAX;
    always @(posedge clk_i)
    begin
        dig_q <= rst_i ? 6'h0 : {dig_q[4:0], dig_reset_pin_i};
        if (rst_i || !frq_bad)
            frq_cnt <= 32'h0;
        else if (frq_cnt < FRQ_LATE)
            frq_cnt <= frq_cnt + 32'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    supply_trip_a: assert property (
        supply_dv_i < `MFS_SUP_MIN |-> ##[1:3] !motor_enable_o)
        else $error("low supply did not stop motor");
    freq_trip_a: assert property (frq_cnt >= FRQ_LATE |-> fault_o)
        else $error("frequency fault late");
    user_fault_a: assert property (
        |user_fault_force_i |-> ##[1:3] fault_o)
        else $error("forced user fault missing");
    user_alarm_a: assert property (
        |user_alarm_force_i |-> ##[1:3] alarm_o)
        else $error("forced user alarm missing");
    stop_cause_a: assert property ($fell(motor_enable_o) |=> fault_o)
        else $error("motor stopped without fault");
    fault_hold_a: assert property (
        fault_o && !dig_reset_pin_i && dig_q == 6'h0
        && !(cyc_i && stb_i && we_i) |=> fault_o)
        else $error("fault dropped without reset");
endmodule
bind mfs_supervisor mfs_supervisor_properties #(.MS_CYCLES(MS_CYCLES)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .supply_dv_i(supply_dv_i),
    .freq_dhz_i(freq_dhz_i), .user_fault_force_i(user_fault_force_i),
    .user_alarm_force_i(user_alarm_force_i),
    .dig_reset_pin_i(dig_reset_pin_i), .motor_enable_o(motor_enable_o),
    .fault_o(fault_o), .alarm_o(alarm_o));

// ---- dv/mfs_supervisor_tb_top.sv ----
// Self-checking bench for the fault supervisor with a bypass relay model.
// Assumes a 1 ms tick of 4 cycles; read data is checked from a note queue.
`timescale 1ns/100ps
`include "mfs_map.vh"
module mfs_supervisor_tb_top;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ramp_end_i;
    logic        full_voltage_i, motor_running_i, user_program_present_i;
    logic        bypass_cmd_i, dig_reset_pin_i, stk_c, stk_o;
    logic [7:0]  adr_i, torque_pct_i, power_pct_i;
    logic [3:0]  sel_i, user_fault_force_i, user_alarm_force_i;
    logic [31:0] dat_i, ctrl_v;
    logic [15:0] supply_dv_i, freq_dhz_i, cur_a_i, cur_b_i, cur_c_i, r;
    wire  [31:0] dat_o;
    wire  [7:0]  code;
    wire         ack_o, contact, en, flt, alm, irq;
    logic [31:0] notes[$];
    int          fail_count = 0;
    int          samples_checked = 0;
    mfs_supervisor #(.MS_CYCLES(4)) dut_u (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .supply_dv_i, .freq_dhz_i, .cur_a_i, .cur_b_i,
        .cur_c_i, .torque_pct_i, .power_pct_i, .ramp_end_i,
        .full_voltage_i, .motor_running_i, .user_program_present_i,
        .user_fault_force_i, .user_alarm_force_i, .bypass_cmd_i,
        .bypass_closed_pin_i(contact), .dig_reset_pin_i,
        .motor_enable_o(en), .fault_o(flt), .fault_code_o(code),
        .alarm_o(alm), .irq_o(irq));
    mfs_bypass_model relay_u (.clk_i(clk_i), .cmd_i(bypass_cmd_i),
        .stuck_closed_i(stk_c), .stuck_open_i(stk_o), .contact_o(contact));
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task close_out;
        $display("compared %0d, mismatched %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task bad(input string m);
        fail_count++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Looks at settled pins mid-cycle: {enable, fault, alarm, irq}
    task pins(input logic [3:0] e);
        @(negedge clk_i);
        samples_checked++;
        if ({en, flt, alm, irq} !== e)
            bad("output pins differ");
        @(posedge clk_i);
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20)
        begin
            bad("no bus answer");
            close_out;
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task cfg(input logic [31:0] v);
        ctrl_v = v;
        wr(`MFS_CTRL, v);
    endtask
    task clr;
        wr(`MFS_CTRL, ctrl_v | 32'h100);
    endtask
    task cur(input logic [15:0] v);
        cur_a_i <= v;
        cur_b_i <= v;
        cur_c_i <= v;
    endtask
    // The code pin is judged mid-cycle, away from the edge that moves it
    task code_is(input logic [7:0] c);
        idle(4);
        rd(`MFS_CODE, {24'h0, c});
        @(negedge clk_i);
        samples_checked++;
        if (code !== c)
            bad("fault code pin differs");
        @(posedge clk_i);
    endtask
    // Read data is judged when ack shows, against the oldest note
    always @(negedge clk_i)
        if (ack_o === 1'b1 && we_i === 1'b0)
        begin
            samples_checked++;
            if (notes.size() == 0)
                bad("read without a note");
            else if (dat_o !== notes.pop_front())
                bad("read data differs");
        end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        {cyc_i, stb_i, we_i, ramp_end_i, full_voltage_i, stk_c} = '0;
        {user_program_present_i, bypass_cmd_i, dig_reset_pin_i} = '0;
        {stk_o, adr_i, user_fault_force_i, user_alarm_force_i} = '0;
        {dat_i, motor_running_i} = '0;
        sel_i = 4'hF;
        rst_i = 1'b1;
        void'($urandom(11854));
        r = 16'h0028 + 16'($urandom % 20);
        supply_dv_i = 16'h0400 + 16'($urandom % 256);
        freq_dhz_i = 16'h0258;
        {torque_pct_i, power_pct_i} = 16'h3232;
        {cur_a_i, cur_b_i, cur_c_i} = {r, r, r};
        ctrl_v = `MFS_CTRL_RST;
        idle(6);
        rst_i <= 1'b0;
        idle(2);
        pins(4'b1000);
        rd(`MFS_CTRL, `MFS_CTRL_RST);
        rd(8'h40, 32'h0);
        wr(`MFS_CODE, 32'hFF);
        code_is(`MFS_NONE);
        wr(`MFS_RATED, 32'h0064_0064);
        wr(`MFS_IMB, 32'h0005_0032);
        wr(`MFS_TIMES, 32'h0005_0005);
        wr(`MFS_LIMITS, 32'h5A28_5A28);
        wr(`MFS_MASK, 32'h3);
        $display("test setup ended");
        supply_dv_i <= `MFS_SUP_MIN - 16'h1;
        code_is(`MFS_E70);
        pins(4'b0101);
        rd(`MFS_HIST_LO, 32'h0);
        supply_dv_i <= `MFS_SUP_MIN;
        clr;
        wr(`MFS_STATUS, 32'h3);
        code_is(`MFS_NONE);
        pins(4'b1000);
        $display("test supply ended");
        motor_running_i <= 1'b1;
        wr(`MFS_MASK, 32'h0);
        ramp_end_i <= 1'b1;
        cur(16'h00C7);
        code_is(`MFS_NONE);
        cur(16'h00C8);
        code_is(`MFS_E72);
        pins(4'b0100);
        rd(`MFS_HIST_LO, {24'h0, `MFS_E72});
        cur(16'h000A);
        dig_reset_pin_i <= 1'b1;
        idle(2);
        dig_reset_pin_i <= 1'b0;
        code_is(`MFS_NONE);
        cur(16'h0009);
        code_is(`MFS_E76);
        rd(`MFS_HIST_LO, {16'h0, `MFS_E72, `MFS_E76});
        cfg(32'h2);
        clr;
        code_is(`MFS_NONE);
        ramp_end_i <= 1'b0;
        cur(r);
        cfg(32'h3);
        $display("test ramp end ended");
        cur_a_i <= r + 16'h32;
        idle(40);
        code_is(`MFS_NONE);
        cur_a_i <= r + 16'h33;
        code_is(`MFS_NONE);
        idle(30);
        code_is(`MFS_E74);
        cur(r);
        clr;
        stk_c <= 1'b1;
        code_is(`MFS_E77);
        cfg(32'h1);
        clr;
        code_is(`MFS_NONE);
        stk_c <= 1'b0;
        idle(4);
        cfg(32'h3);
        {bypass_cmd_i, full_voltage_i, stk_o} <= 3'b111;
        code_is(`MFS_E71);
        {bypass_cmd_i, full_voltage_i, stk_o} <= 3'b000;
        clr;
        code_is(`MFS_NONE);
        $display("test current and bypass ended");
        for (int i = 0; i < 2; i++)
        begin
            freq_dhz_i <= i ? `MFS_FRQ_MAX + 16'h1 : `MFS_FRQ_MIN - 16'h1;
            idle(1980);
            rd(`MFS_CODE, 32'h0);
            // Trip needs 501 ticks of 4 cycles plus the latch cycle
            idle(30);
            code_is(`MFS_E75);
            idle(60);
            freq_dhz_i <= `MFS_FRQ_MAX;
            clr;
            code_is(`MFS_NONE);
        end
        freq_dhz_i <= `MFS_FRQ_MIN - 16'h1;
        idle(1500);
        freq_dhz_i <= `MFS_FRQ_MAX;
        idle(1);
        freq_dhz_i <= `MFS_FRQ_MIN - 16'h1;
        idle(1500);
        rd(`MFS_CODE, 32'h0);
        freq_dhz_i <= 16'h0258;
        $display("test frequency ended");
        cfg(32'h7);
        code_is(`MFS_E85);
        user_program_present_i <= 1'b1;
        clr;
        code_is(`MFS_NONE);
        cfg(32'h3);
        for (int k = 0; k < 4; k++)
        begin
            user_fault_force_i <= 4'h1 << k;
            code_is(`MFS_E86 + 8'(k));
            user_fault_force_i <= 4'h0;
            clr;
        end
        wr(`MFS_STATUS, 32'h3);
        wr(`MFS_MASK, 32'h2);
        user_alarm_force_i <= 4'h4;
        idle(3);
        user_alarm_force_i <= 4'h0;
        idle(3);
        pins(4'b1011);
        rd(`MFS_CODE, 32'h0000_4000);
        clr;
        wr(`MFS_STATUS, 32'h3);
        pins(4'b1000);
        $display("test user codes ended");
        cfg(32'hF3);
        for (int k = 0; k < 4; k++)
        begin
            torque_pct_i <= k == 0 ? 8'h1E : k == 1 ? 8'h5F : 8'h32;
            power_pct_i <= k == 2 ? 8'h1E : k == 3 ? 8'h5F : 8'h32;
            idle(40);
            rd(`MFS_CODE, 32'h100 << k);
            pins(4'b1011);
            {torque_pct_i, power_pct_i} <= 16'h3232;
            idle(4);
            wr(`MFS_STATUS, 32'h3);
            pins(4'b1000);
        end
        cfg(32'h3);
        torque_pct_i <= 8'h1E;
        idle(40);
        code_is(`MFS_E78);
        pins(4'b0100);
        $display("test torque and power ended");
        close_out;
    end
endmodule
